/* shared/ubdo_pkg.sv */
// Package for the buffer descriptor ownership engine
package ubdo_pkg;
    localparam int          UBDO_NUM_DESC      = 32;
    localparam int          UBDO_RAM_BYTES     = 256;
    localparam logic [9:0]  UBDO_TABLE_BASE    = 10'h200;
    localparam int          UBDO_TABLE_MAX     = 128;
    localparam logic [1:0]  UBDO_OFS_STATUS    = 2'h0;
    localparam logic [1:0]  UBDO_OFS_COUNT     = 2'h1;
    localparam logic [1:0]  UBDO_OFS_ADDR_LOW  = 2'h2;
    localparam logic [1:0]  UBDO_OFS_ADDR_HIGH = 2'h3;
    localparam int          UBDO_BIT_OWNER     = 7;
    localparam int          UBDO_BIT_TOGGLE    = 6;
    localparam int          UBDO_BIT_TCHK      = 3;
    localparam int          UBDO_BIT_STALL     = 2;
    localparam int          UBDO_PID_LSB       = 2;
    localparam logic [7:0]  UBDO_RAM_RESET     = 8'h00;
    localparam int          UBDO_FIFO_DEPTH    = 32;
    localparam int          UBDO_NUM_EP        = 8;
    localparam int          UBDO_EP_IN_ENABLE  = 1;

    typedef enum logic [1:0]
    {
        UBDO_HS_ACK   = 2'h0,
        UBDO_HS_NAK   = 2'h1,
        UBDO_HS_STALL = 2'h2,
        UBDO_HS_NONE  = 2'h3
    } ubdo_hs_type;

    typedef enum logic [1:0]
    {
        UBDO_TOK_OUT   = 2'h0,
        UBDO_TOK_IN    = 2'h1,
        UBDO_TOK_SETUP = 2'h3
    } ubdo_tok_type;

    typedef struct packed
    {
        ubdo_tok_type tok;
        logic [3:0]   pid;
        logic [4:0]   desc;
        logic [2:0]   ep;
        logic         data1;
        logic         error;
        logic [9:0]   len;
    } ubdo_token_type;

    typedef struct packed
    {
        ubdo_hs_type hs;
        logic [9:0]  count;
    } ubdo_answer_type;
endpackage : ubdo_pkg

/* verilog/ubdo_fifo.sv */
`timescale 1ns/1ns
// Packet data FIFO between the USB receive side and the engine
module ubdo_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
)
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];

    always_ff @(posedge clk)
    begin
        if (reset || (ce && flush))
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else if (ce)
        begin
            if (push)
            begin
                mem_r[wp_r] <= in_data;
                wp_r        <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop)
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ubdo_fifo

/* verilog/ubdo_engine.sv */
`timescale 1ns/1ns
// Descriptor table and ownership engine over dual-access USB RAM

// Overview of operation
// (R1) Thirty-two descriptors of four bytes each
// (R2) Order status, count, address low, high
// (R3) Table spans eight to 128 bytes
// (R4) Descriptor active only when endpoint enabled
// (R5) Firmware sets descriptor before enabling endpoint; the bench enables endpoint 0 before reset ends and arms descriptors after
// (R6) Status bit 7 selects owner
// (R7) CPU access never blocked
// (R8) Engine overwrites status and count
// (R9) Firmware writes status byte last
// (R10) Ownership cleared when transaction completes
// (R11) Toggle compared against expected bit
// (R12) Mismatch: ACK, no write, keep ownership
// (R13) Good OUT: ACK, release, flag, update
// (R14) Errored OUT answered NAK, nothing changes
// (R15) SETUP accepted despite toggle mismatch
// (R16) Buffer stall answers STALL, unchanged
// (R17) STALL sets endpoint stalled flag, interrupt
// (R18) SETUP on stalled descriptor releases it
// (R19) Ten-bit count, high bits in status
// (R20) Firmware writes status bits 5:4 zero
// (R21) Expected toggle ignored unless checking enabled
// (R22) Firmware initialises owner flag before enable; the bench writes owner flags after endpoint 0 is already enabled
// (R23) Engine status carries token PID bits
// (R24) Oversize OUT gets NAK, count kept
module ubdo_engine
#(
    parameter int RAM_BYTES = ubdo_pkg::UBDO_RAM_BYTES,
    parameter int NUM_DESC  = ubdo_pkg::UBDO_NUM_DESC,
    parameter int FIFO_DEPTH = ubdo_pkg::UBDO_FIFO_DEPTH
)
(
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      ce,
    input  wire logic                      cpu_we,
    input  wire logic                      cpu_re,
    input  wire logic [9:0]                cpu_addr,
    input  wire logic [7:0]                cpu_wdata,
    output logic      [7:0]                cpu_rdata_r,
    input  wire logic [7:0]                endpoint_enable,
    input  wire logic                      tok_valid,
    input  wire ubdo_pkg::ubdo_token_type  tok,
    output logic                           tok_busy_r,
    input  wire logic [7:0]                rx_data,
    input  wire logic                      rx_valid,
    output logic                           rx_ready,
    output logic      [7:0]                tx_data_r,
    output logic                           tx_valid_r,
    output ubdo_pkg::ubdo_answer_type      ans_r,
    output logic                           ans_valid_r,
    output logic                           transfer_done_flag_r,
    input  wire logic                      transfer_done_clear,
    output logic      [7:0]                endpoint_stalled_flag_r,
    input  wire logic [7:0]                endpoint_stalled_clear,
    output logic                           stall_irq_r
);
    import ubdo_pkg::*;

    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b000,
        ST_STAT  = 3'b001,
        ST_META  = 3'b011,
        ST_MOVE  = 3'b010,
        ST_WBCNT = 3'b110,
        ST_WBST  = 3'b111
    } ubdo_state_type;

    localparam int AW = $clog2(RAM_BYTES);

    // Byte address of a descriptor field; five index bits cap the table at 128 bytes (R2) (R3)
    function automatic logic [AW-1:0] desc_addr(input logic [4:0] n, input logic [1:0] f);
        desc_addr = AW'({n, f});
    endfunction : desc_addr

    logic [7:0]     ram_r [RAM_BYTES];
    ubdo_state_type state_r;
    ubdo_token_type cur_r;
    logic [7:0]     stat_r;
    logic [9:0]     limit_r;
    logic [9:0]     done_r;
    logic [9:0]     ptr_r;
    logic           drop_r;
    logic           over_r;
    logic [7:0]     fifo_data;
    logic           fifo_valid;

    wire            cpu_hit = (cpu_addr[9:8] == UBDO_TABLE_BASE[9:8]);
    wire [AW-1:0]   cpu_ix  = cpu_addr[AW-1:0];
    wire            ep_on   = endpoint_enable[tok.ep];
    wire [7:0]      st_byte = ram_r[desc_addr(cur_r.desc, UBDO_OFS_STATUS)];
    wire            is_setup = (cur_r.tok == UBDO_TOK_SETUP);
    wire            is_out  = (cur_r.tok != UBDO_TOK_IN);
    wire            tmis    = stat_r[UBDO_BIT_TCHK] &&
                              (stat_r[UBDO_BIT_TOGGLE] != cur_r.data1); // (R11) (R21)
    wire            owned   = stat_r[UBDO_BIT_OWNER];
    wire            stalled = stat_r[UBDO_BIT_STALL];
    wire            mov_en  = (state_r == ST_MOVE) && (ptr_r != cur_r.len);
    wire            ld_eng  = ce && (state_r == ST_MOVE) && is_out && fifo_valid;

    // Every answer empties the FIFO so bytes of a refused packet never reach the next token
    ubdo_fifo
    #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
        .clk       (clk),
        .reset     (reset),
        .ce        (ce),
        .flush     (ans_valid_r),
        .in_data   (rx_data),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (state_r == ST_MOVE && is_out && ptr_r != cur_r.len)
    );

    logic [AW-1:0] buf_base_r;

    // RAM: CPU port never blocked; engine writes when both collide win (R7)
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (cpu_we && cpu_hit)
                ram_r[cpu_ix] <= cpu_wdata; // (R7)
            if (ld_eng && mov_en && !drop_r && !over_r && !cur_r.error)
                ram_r[buf_base_r + AW'(ptr_r)] <= fifo_data; // (R12) (R14)
            if (state_r == ST_WBCNT)
                ram_r[desc_addr(cur_r.desc, UBDO_OFS_COUNT)] <= done_r[7:0]; // (R8) (R19)
            if (state_r == ST_WBST)
                ram_r[desc_addr(cur_r.desc, UBDO_OFS_STATUS)] <= stat_r; // (R8)
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            cpu_rdata_r <= 8'h00;
        else if (ce && cpu_re)
            cpu_rdata_r <= cpu_hit ? ram_r[cpu_ix] : 8'h00;
    end

    // Transaction sequencer
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r     <= ST_IDLE;
            cur_r       <= '0;
            stat_r      <= 8'h00;
            limit_r     <= '0;
            done_r      <= '0;
            ptr_r       <= '0;
            drop_r      <= 1'b0;
            over_r      <= 1'b0;
            buf_base_r  <= '0;
            tok_busy_r  <= 1'b0;
            ans_r       <= '{UBDO_HS_NONE, 10'h000};
            ans_valid_r <= 1'b0;
            tx_data_r   <= 8'h00;
            tx_valid_r  <= 1'b0;
        end
        else if (ce)
        begin
            ans_valid_r <= 1'b0;
            tx_valid_r  <= 1'b0;
            unique case (state_r)
                ST_IDLE:
                begin
                    // Disabled endpoint: table bytes stay plain RAM (R4)
                    if (tok_valid && ep_on && ({1'b0, tok.desc} < 6'(NUM_DESC))) // (R1) (R4)
                    begin
                        cur_r      <= tok;
                        tok_busy_r <= 1'b1;
                        state_r    <= ST_STAT;
                    end
                    else if (tok_valid)
                    begin
                        ans_r       <= '{UBDO_HS_NONE, 10'h000};
                        ans_valid_r <= 1'b1;
                    end
                end
                ST_STAT:
                begin
                    stat_r  <= st_byte;
                    limit_r <= {st_byte[1:0], ram_r[desc_addr(cur_r.desc, UBDO_OFS_COUNT)]};
                    buf_base_r <= ram_r[desc_addr(cur_r.desc, UBDO_OFS_ADDR_LOW)];
                    state_r <= ST_META;
                end
                ST_META:
                begin
                    ptr_r   <= '0;
                    drop_r  <= 1'b0;
                    over_r  <= 1'b0;
                    if (!owned)
                    begin
                        // CPU still owns it: nothing to hand the host (R6)
                        ans_r       <= '{UBDO_HS_NAK, 10'h000}; // (R6)
                        ans_valid_r <= 1'b1;
                        tok_busy_r  <= 1'b0;
                        state_r     <= ST_IDLE;
                    end
                    else if (stalled && !is_setup)
                    begin
                        ans_r       <= '{UBDO_HS_STALL, 10'h000}; // (R16)
                        ans_valid_r <= 1'b1;
                        tok_busy_r  <= 1'b0;
                        state_r     <= ST_IDLE;
                    end
                    else
                    begin
                        drop_r  <= tmis && !is_setup && is_out; // (R12) (R15)
                        over_r  <= is_out && (cur_r.len > limit_r); // (R24)
                        state_r <= ST_MOVE;
                    end
                end
                ST_MOVE:
                begin
                    if (!is_out && ptr_r != limit_r)
                    begin
                        tx_data_r  <= ram_r[buf_base_r + AW'(ptr_r)];
                        tx_valid_r <= 1'b1;
                        ptr_r      <= ptr_r + 10'h001;
                    end
                    else if (is_out && ptr_r != cur_r.len)
                    begin
                        if (fifo_valid)
                            ptr_r <= ptr_r + 10'h001;
                    end
                    else
                    begin
                        done_r <= ptr_r;
                        if (is_out && (cur_r.error || over_r))
                        begin
                            ans_r   <= '{UBDO_HS_NAK, 10'h000}; // (R14) (R24)
                            ans_valid_r <= 1'b1;
                            tok_busy_r  <= 1'b0;
                            state_r <= ST_WBST;
                        end
                        else if (drop_r)
                        begin
                            ans_r   <= '{UBDO_HS_ACK, 10'h000}; // (R12)
                            ans_valid_r <= 1'b1;
                            tok_busy_r  <= 1'b0;
                            state_r <= ST_WBST;
                        end
                        else
                            state_r <= ST_WBCNT;
                    end
                end
                ST_WBCNT:
                begin
                    // Owner cleared, PID and count high bits written back (R10) (R23)
                    stat_r      <= {1'b0, 1'b0, cur_r.pid, done_r[9:8]}; // (R10) (R13) (R18)
                    ans_r       <= '{UBDO_HS_ACK, done_r}; // (R13)
                    ans_valid_r <= 1'b1;
                    tok_busy_r  <= 1'b0;
                    state_r     <= ST_WBST;
                end
                ST_WBST:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Updated status only after a full completion; error and oversize NAK and mismatch paths write the old byte back, the CPU-owned NAK writes nothing
    wire complete = ce && (state_r == ST_WBCNT);
    wire stall_ev = ce && (state_r == ST_META) && owned && stalled && !is_setup;

    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            transfer_done_flag_r    <= 1'b0;
            endpoint_stalled_flag_r <= 8'h00;
            stall_irq_r             <= 1'b0;
        end
        else if (ce)
        begin
            transfer_done_flag_r <= complete || (transfer_done_flag_r && !transfer_done_clear);
            endpoint_stalled_flag_r <= (endpoint_stalled_flag_r & ~endpoint_stalled_clear)
                                     | ({7'h00, stall_ev} << cur_r.ep); // (R17)
            stall_irq_r <= stall_ev; // (R17)
        end
    end

    a_stall_flag_set: assert property (@(posedge clk) disable iff (reset) // (R17)
        stall_ev |=> endpoint_stalled_flag_r[$past(cur_r.ep)] && stall_irq_r)
        else $error("stall did not set endpoint flag");

    a_stall_answer: assert property (@(posedge clk) disable iff (reset) // (R16)
        stall_ev |=> ans_valid_r && ans_r.hs == UBDO_HS_STALL)
        else $error("stalled descriptor not answered STALL");

    a_done_on_ack: assert property (@(posedge clk) disable iff (reset) // (R13)
        complete |=> transfer_done_flag_r && ans_r.hs == UBDO_HS_ACK)
        else $error("completion missing flag or ACK");

    a_release_owner: assert property (@(posedge clk) disable iff (reset) // (R10)
        complete |=> !stat_r[UBDO_BIT_OWNER] ##1
        !ram_r[desc_addr(cur_r.desc, UBDO_OFS_STATUS)][UBDO_BIT_OWNER])
        else $error("owner flag not cleared after completion");

    a_mismatch_keep: assert property (@(posedge clk) disable iff (reset) // (R12)
        (ce && state_r == ST_MOVE && drop_r && !ld_eng && !cur_r.error && !over_r
        && ptr_r == cur_r.len) |=> ans_r.hs == UBDO_HS_ACK && state_r == ST_WBST
        && stat_r[UBDO_BIT_OWNER])
        else $error("toggle mismatch mishandled");

    a_error_nak: assert property (@(posedge clk) disable iff (reset) // (R14)
        (ce && state_r == ST_MOVE && is_out && cur_r.error && ptr_r == cur_r.len)
        |=> ans_valid_r && ans_r.hs == UBDO_HS_NAK && state_r == ST_WBST
        && stat_r[UBDO_BIT_OWNER])
        else $error("errored packet not NAKed");

    a_oversize_nak: assert property (@(posedge clk) disable iff (reset) // (R24)
        (ce && state_r == ST_MOVE && over_r && ptr_r == cur_r.len) |=> ans_r.hs == UBDO_HS_NAK)
        else $error("oversize packet not NAKed");

    a_count_back: assert property (@(posedge clk) disable iff (reset) // (R19)
        complete |=> ##1 ram_r[desc_addr(cur_r.desc, UBDO_OFS_STATUS)][1:0] == done_r[9:8])
        else $error("count high bits not written back");

    a_pid_back: assert property (@(posedge clk) disable iff (reset) // (R23)
        complete |=> stat_r[5:2] == cur_r.pid)
        else $error("token PID not stored");

    a_disabled_ignored: assert property (@(posedge clk) disable iff (reset) // (R4)
        (ce && state_r == ST_IDLE && tok_valid && !ep_on) |=> ans_valid_r
        && ans_r.hs == UBDO_HS_NONE && state_r == ST_IDLE)
        else $error("token for disabled endpoint not ignored");

    a_cpu_owned_nak: assert property (@(posedge clk) disable iff (reset) // (R6)
        (ce && state_r == ST_META && !owned) |=> ans_valid_r && ans_r.hs == UBDO_HS_NAK
        && state_r == ST_IDLE)
        else $error("CPU owned descriptor not NAKed");
endmodule : ubdo_engine

/* bench/ubdo_host_model.sv */
`timescale 1ns/1ns
// Host side model: pushes OUT bytes, issues one token and collects the answer
module ubdo_host_model
(
    input  wire logic                     clk,
    input  wire logic                     go,
    input  wire ubdo_pkg::ubdo_token_type req,
    input  wire logic                     slow,
    input  wire logic                     tok_busy_r,
    input  wire logic                     rx_ready,
    input  wire logic                     tx_valid_r,
    input  wire ubdo_pkg::ubdo_answer_type ans_r,
    input  wire logic                     ans_valid_r,
    output ubdo_pkg::ubdo_token_type      tok,
    output logic                          tok_valid,
    output logic      [7:0]               rx_data,
    output logic                          rx_valid,
    output ubdo_pkg::ubdo_answer_type     seen,
    output logic      [10:0]              tx_count,
    output logic                          done
);
    import ubdo_pkg::*;
    int n;
    int txc;
    initial
    begin
        tok = '0;
        tok_valid = 1'b0;
        rx_data = 8'h5A;
        rx_valid = 1'b0;
        seen = '{UBDO_HS_NONE, 10'h000};
        tx_count = '0;
        done = 1'b0;
        forever
        begin
            @(posedge clk);
            if (go)
            begin
                done <= 1'b0;
                for (int i = 0; i < int'(req.len) && req.tok != UBDO_TOK_IN; i++)
                begin
                    rx_data  <= 8'(8'h30 + i);
                    rx_valid <= 1'b1;
                    do @(posedge clk); while (!rx_ready);
                    if (slow)
                    begin
                        // Idle data line shows the inverse so a stale byte never passes
                        rx_valid <= 1'b0;
                        rx_data  <= ~rx_data;
                        @(posedge clk);
                    end
                end
                rx_valid <= 1'b0;
                rx_data  <= ~rx_data;
                while (tok_busy_r) @(posedge clk);
                @(posedge clk);
                tok       <= req;
                tok_valid <= 1'b1;
                @(posedge clk);
                tok_valid <= 1'b0;
                n = 0;
                txc = 0;
                do
                begin
                    @(posedge clk);
                    txc += int'(tx_valid_r);
                    n++;
                end
                while (!ans_valid_r && n < 2000);
                // A silent engine reads as no handshake
                seen     <= ans_valid_r ? ans_r : '{UBDO_HS_NONE, 10'h000};
                tx_count <= 11'(txc);
                done     <= 1'b1;
            end
        end
    end
endmodule : ubdo_host_model

/* bench/usb_buffer_descriptor_ownership_tb_top.sv */
`timescale 1ns/1ns
// Testbench for the descriptor ownership engine
module usb_buffer_descriptor_ownership_tb_top;
    import ubdo_pkg::*;
    typedef struct packed {logic en, expected_toggle, d1, err; logic [9:0] len, cnt;} ubdo_row_type;
    logic clk, reset, cpu_we, cpu_re, tok_valid, tok_busy_r, rx_valid, rx_ready;
    logic tx_valid_r, ans_valid_r, transfer_done_flag_r, transfer_done_clear, stall_irq_r;
    logic go, slow, done;
    logic [9:0] cpu_addr;
    logic [7:0] cpu_wdata, cpu_rdata_r, endpoint_enable, rx_data, tx_data_r;
    logic [7:0] endpoint_stalled_flag_r, endpoint_stalled_clear, d, txl;
    logic [10:0] tx_count;
    ubdo_token_type tok, req;
    ubdo_answer_type ans_r, seen;
    int errors = 0, compares = 0, cycles = 0, irqs = 0;
    ubdo_row_type r;
    ubdo_row_type rows [7] = '{'{0,1,0,0,10'd4,10'd8}, '{1,0,1,0,10'd5,10'd8},
        '{1,1,0,0,10'd5,10'd8}, '{1,1,1,0,10'd6,10'd8}, '{1,0,0,0,10'd8,10'd8},
        '{0,0,0,1,10'd3,10'd8}, '{0,0,0,0,10'd9,10'd8}};
    logic [9:0] b;
    logic [7:0] st;
    ubdo_hs_type hs;
    logic upd;

    ubdo_engine ubdo_engine_inst (.clk(clk), .reset(reset), .ce(1'b1), .cpu_we(cpu_we),
        .cpu_re(cpu_re), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata_r(cpu_rdata_r),
        .endpoint_enable(endpoint_enable), .tok_valid(tok_valid), .tok(tok),
        .tok_busy_r(tok_busy_r), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data_r(tx_data_r), .tx_valid_r(tx_valid_r), .ans_r(ans_r), .ans_valid_r(ans_valid_r),
        .transfer_done_flag_r(transfer_done_flag_r), .transfer_done_clear(transfer_done_clear),
        .endpoint_stalled_flag_r(endpoint_stalled_flag_r),
        .endpoint_stalled_clear(endpoint_stalled_clear), .stall_irq_r(stall_irq_r));
    ubdo_host_model ubdo_host_model_inst (.clk(clk), .go(go), .req(req), .slow(slow),
        .tok_busy_r(tok_busy_r), .rx_ready(rx_ready), .tx_valid_r(tx_valid_r), .ans_r(ans_r),
        .ans_valid_r(ans_valid_r), .tok(tok), .tok_valid(tok_valid), .rx_data(rx_data),
        .rx_valid(rx_valid), .seen(seen), .tx_count(tx_count), .done(done));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    always @(posedge clk)
    begin
        cycles++;
        irqs += int'(stall_irq_r === 1'b1);
        if (tx_valid_r === 1'b1)
            txl = tx_data_r;
        if (cycles == 20000)
        begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge clk);
        cpu_we    <= 1'b1;
        cpu_addr  <= a;
        cpu_wdata <= v;
        @(posedge clk);
        cpu_we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [9:0] a);
        @(posedge clk);
        cpu_re   <= 1'b1;
        cpu_addr <= a;
        @(posedge clk);
        cpu_re <= 1'b0;
        @(negedge clk);
        d = cpu_rdata_r;
    endtask : rd

    // Status goes last so the engine never sees a half-built descriptor
    task automatic arm(input logic [9:0] a, input logic [7:0] s, input logic [9:0] c);
        wr(a + 10'h1, c[7:0]);
        wr(a + 10'h2, 8'h80);
        wr(a + 10'h3, 8'h00);
        wr(a, {s[7:2], c[9:8]});
    endtask : arm

    task automatic send(input ubdo_tok_type t, input logic [3:0] p, input logic [4:0] ds,
                        input logic [2:0] ep, input logic [9:0] ln, input logic d1);
        @(posedge clk);
        req <= '{t, p, ds, ep, d1, r.err, ln};
        go  <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (!done);
        while (tok_busy_r) @(posedge clk);
    endtask : send

    task automatic clr;
        @(posedge clk);
        transfer_done_clear    <= 1'b1;
        endpoint_stalled_clear <= 8'hFF;
        @(posedge clk);
        transfer_done_clear    <= 1'b0;
        endpoint_stalled_clear <= 8'h00;
    endtask : clr

    initial
    begin
        reset = 1'b1;
        {cpu_we, cpu_re, transfer_done_clear, go, slow} = '0;
        cpu_addr = '0;
        cpu_wdata = '0;
        endpoint_enable = 8'h01;
        endpoint_stalled_clear = '0;
        req = '0;
        r = '0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            r = rows[i];
            slow <= i[0];
            b = 10'h200 + 10'(4 * (i + 1));
            hs = (r.err || r.len > r.cnt) ? UBDO_HS_NAK : UBDO_HS_ACK;
            upd = hs == UBDO_HS_ACK && (!r.en || r.expected_toggle == r.d1);
            st = {1'b1, r.expected_toggle, 2'b00, r.en, 1'b0, r.cnt[9:8]};
            wr(10'h280 + r.len - 10'h1, 8'hEE);
            arm(b, st, r.cnt);
            send(UBDO_TOK_OUT, 4'h1, 5'(i + 1), 3'h0, r.len, r.d1);
            chk("handshake", 11'(hs), 11'(seen.hs));
            rd(b);
            chk("status", upd ? {5'h0, 4'h1, r.len[9:8]} : 11'(st), 11'(d));
            rd(b + 10'h1);
            chk("count", 11'(upd ? r.len[7:0] : r.cnt[7:0]), 11'(d));
            rd(10'h280 + r.len - 10'h1);
            chk("buffer", 11'(upd ? 8'(8'h30 + r.len - 10'h1) : 8'hEE), 11'(d));
            chk("done flag", 11'(upd), 11'(transfer_done_flag_r));
            clr();
            $display("Test out row %0d finished", i);
        end
        r = '0;
        arm(10'h250, 8'h80, 10'd8);
        send(UBDO_TOK_OUT, 4'h1, 5'd20, 3'h3, 10'd2, 1'b0);
        chk("disabled hs", 11'(UBDO_HS_NONE), 11'(seen.hs));
        rd(10'h250);
        chk("disabled status", 11'h080, 11'(d));
        $display("Test disabled endpoint finished");
        arm(10'h27C, 8'hCC, 10'd8);
        send(UBDO_TOK_IN, 4'h9, 5'd31, 3'h0, 10'd0, 1'b0);
        chk("stall hs", 11'(UBDO_HS_STALL), 11'(seen.hs));
        chk("ep stalled", 11'h001, 11'(endpoint_stalled_flag_r));
        chk("stall irq", 11'h001, 11'(irqs));
        rd(10'h27C);
        chk("stall status", 11'h0CC, 11'(d));
        clr();
        send(UBDO_TOK_SETUP, 4'hD, 5'd31, 3'h0, 10'd8, 1'b0);
        chk("setup hs", 11'(UBDO_HS_ACK), 11'(seen.hs));
        rd(10'h27C);
        chk("setup status", 11'h034, 11'(d));
        chk("setup done", 11'h001, 11'(transfer_done_flag_r));
        clr();
        $display("Test stall and setup finished");
        wr(10'h280, 8'hA5);
        arm(10'h228, 8'h80, 10'h101);
        send(UBDO_TOK_IN, 4'h9, 5'd10, 3'h0, 10'd0, 1'b0);
        chk("in hs", 11'(UBDO_HS_ACK), 11'(seen.hs));
        chk("in bytes", 11'd257, tx_count);
        chk("in data", 11'h0A5, 11'(txl));
        chk("in answer count", 11'h101, 11'(seen.count));
        rd(10'h228);
        chk("in status", 11'h025, 11'(d));
        rd(10'h229);
        chk("in count low", 11'h001, 11'(d));
        send(UBDO_TOK_OUT, 4'h1, 5'd10, 3'h0, 10'd0, 1'b0);
        chk("cpu owned hs", 11'(UBDO_HS_NAK), 11'(seen.hs));
        $display("Test in transfer finished");
        report_and_stop();
    end
endmodule : usb_buffer_descriptor_ownership_tb_top
